// ==== hdl/line_interrupt_enable_mask.sv ====
// Operation
// - Mask bits 7..2 gate alarms six to one
// - Mask bit 1 gates loop closure change
// - Mask bit 0 gates ring trip
// - Zero masks a source, one enables it
// - Second mask bit 2 gates calibration error
// - Reset clears every mask bit
// - Writing one clears a pending bit
// - Second mask bit 1 gates indirect done
// - Second mask bit 0 gates tone detect
// - Indirect completion sets its pending flag
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "line_irq_defines.svh"

module line_interrupt_enable_mask
  import line_irq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event pulses from the line logic
  input wire logic [`ALARM_W-1:0] alarmEvent,
  input wire logic loopClosureEvent,
  input wire logic ringTripEvent,
  input wire logic calibErrorEvent,
  input wire logic indirectDoneEvent,
  input wire logic toneDetectEvent,
  // Interrupt
  output logic irqOut
);

  irq_state_t st_ff;
  irq_state_t nxt_st;

  logic setupPhase;
  logic accessPhase;
  logic wordAligned;
  logic hitPend2;
  logic hitPend3;
  logic hitMask2;
  logic hitMask3;
  logic regWrite;
  logic [7:0] wrByte;
  logic [7:0] set2;
  logic [`MASK3_W-1:0] set3;
  logic [7:0] clr2;
  logic [`MASK3_W-1:0] clr3;

  // ----------------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------------
  assign wordAligned = (paddr[1:0] == 2'h0);
  assign hitPend2 = wordAligned && (paddr[`ADDR_W-1:2] == `IDX_PEND2);
  assign hitPend3 = wordAligned && (paddr[`ADDR_W-1:2] == `IDX_PEND3);
  assign hitMask2 = wordAligned && (paddr[`ADDR_W-1:2] == `IDX_MASK2);
  assign hitMask3 = wordAligned && (paddr[`ADDR_W-1:2] == `IDX_MASK3);
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable && st_ff.pready;
  assign regWrite = accessPhase && pwrite && pstrb[0] && !st_ff.pslverr;
  assign wrByte = pwdata[7:0];

  // ----------------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    // The slave answers in the first access cycle, never later.
    nxt_st.pready = setupPhase;
    if (setupPhase)
    begin
      nxt_st.pslverr = !(hitPend2 || hitPend3 || hitMask2 || hitMask3);
      nxt_st.prdata = 32'h0000_0000;
      if (hitPend2)
      begin
        nxt_st.prdata[7:0] = st_ff.pend2;
      end
      else if (hitPend3)
      begin
        nxt_st.prdata[`MASK3_W-1:0] = st_ff.pend3;
      end
      else if (hitMask2)
      begin
        nxt_st.prdata[7:0] = st_ff.mask2;
      end
      else if (hitMask3)
      begin
        nxt_st.prdata[`MASK3_W-1:0] = st_ff.mask3;
      end
    end
    if (regWrite && hitMask2)
    begin
      nxt_st.mask2 = wrByte;
    end
    if (regWrite && hitMask3)
    begin
      nxt_st.mask3 = wrByte[`MASK3_W-1:0];
    end
    // Bit order of the alarm field: alarm six at bit 7, alarm one at bit 2.
    set2 = {alarmEvent, loopClosureEvent, ringTripEvent};
    set3 = {calibErrorEvent, indirectDoneEvent, toneDetectEvent};
    clr2 = (regWrite && hitPend2) ? wrByte : 8'h00;
    clr3 = (regWrite && hitPend3) ? wrByte[`MASK3_W-1:0] : `MASK3_RESET;
    // An event in the cycle of its clear wins over the clear.
    nxt_st.pend2 = (st_ff.pend2 & ~clr2) | set2;
    nxt_st.pend3 = (st_ff.pend3 & ~clr3) | set3;
    // A mask bit of one lets its pending bit through, zero blocks it.
    nxt_st.irq = (|(nxt_st.pend2 & nxt_st.mask2))
               | (|(nxt_st.pend3 & nxt_st.mask3));
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff.mask2 <= `REG_RESET;
      st_ff.mask3 <= `MASK3_RESET;
      st_ff.pend2 <= `REG_RESET;
      st_ff.pend3 <= `MASK3_RESET;
      st_ff.pready <= 1'b0;
      st_ff.pslverr <= 1'b0;
      st_ff.prdata <= 32'h0000_0000;
      st_ff.irq <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign irqOut = st_ff.irq;

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  logic maskWrite;
  assign maskWrite = regWrite && (hitMask2 || hitMask3);

  sequence evtEnabled(logic ev, logic en);
    ev && en && !maskWrite;
  endsequence

  sequence apbSetup;
    psel && !penable;
  endsequence

  a_alarm_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    evtEnabled(|(alarmEvent & st_ff.mask2[7:`ALARM_LO]), 1'b1)
    |=> irqOut)
    else $error("enabled alarm event did not raise the interrupt");

  a_loop_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    evtEnabled(loopClosureEvent, st_ff.mask2[`BIT_LOOP])
    |=> irqOut && st_ff.pend2[`BIT_LOOP])
    else $error("enabled loop closure event did not raise the interrupt");

  a_ring_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    evtEnabled(ringTripEvent, st_ff.mask2[`BIT_RING])
    |=> irqOut && st_ff.pend2[`BIT_RING])
    else $error("enabled ring trip event did not raise the interrupt");

  a_masked_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
    ((st_ff.pend2 & st_ff.mask2) == 8'h00)
    && ((st_ff.pend3 & st_ff.mask3) == `MASK3_RESET)
    |-> !irqOut)
    else $error("interrupt high with no enabled pending bit");

  a_calib_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    evtEnabled(calibErrorEvent, st_ff.mask3[`BIT_CALIB])
    |=> irqOut)
    else $error("enabled calibration error did not raise the interrupt");

  a_reset_masks: assert property (@(posedge core_clk) disable iff (!resetn)
    !$past(resetn) |-> (st_ff.mask2 == `REG_RESET)
    && (st_ff.mask3 == `MASK3_RESET) && !irqOut)
    else $error("masks not clear after reset");

  a_pend_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    regWrite && hitPend2 && (set2 == 8'h00)
    |=> st_ff.pend2 == ($past(st_ff.pend2) & ~$past(wrByte)))
    else $error("pending write did not clear exactly the ones written");

  a_indirect_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    evtEnabled(indirectDoneEvent, st_ff.mask3[`BIT_INDIRECT])
    |=> irqOut)
    else $error("enabled indirect done did not raise the interrupt");

  a_tone_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    evtEnabled(toneDetectEvent, st_ff.mask3[`BIT_TONE])
    |=> irqOut ##0 st_ff.pend3[`BIT_TONE])
    else $error("enabled tone detect did not raise the interrupt");

  a_indirect_set: assert property (@(posedge core_clk) disable iff (!resetn)
    indirectDoneEvent |=> st_ff.pend3[`BIT_INDIRECT])
    else $error("indirect completion did not set its pending bit");

  a_irq_follows: assert property (@(posedge core_clk) disable iff (!resetn)
    (|(st_ff.pend2 & st_ff.mask2)) |-> irqOut)
    else $error("enabled pending bit without interrupt");

  a_apb_answer: assert property (@(posedge core_clk) disable iff (!resetn)
    apbSetup |=> pready ##1 !pready)
    else $error("slave did not answer in the first access cycle");

endmodule : line_interrupt_enable_mask
`default_nettype wire

// ==== hdl/line_irq_defines.svh ====
`ifndef LINE_IRQ_DEFINES_SVH
`define LINE_IRQ_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------
`define IDX_PEND2 10'h013
`define IDX_PEND3 10'h014
`define IDX_MASK2 10'h016
`define IDX_MASK3 10'h017
`define ADDR_W 12

// ----------------------------------------------------------------------
// Reset values and field layout.
// ----------------------------------------------------------------------
`define REG_RESET 8'h00
`define MASK3_RESET 3'h0
`define MASK3_W 3
`define ALARM_W 6
`define ALARM_LO 2
`define BIT_LOOP 1
`define BIT_RING 0
`define BIT_CALIB 2
`define BIT_INDIRECT 1
`define BIT_TONE 0

`endif

// ==== hdl/line_irq_pkg.sv ====
`include "line_irq_defines.svh"

package line_irq_pkg;

  typedef struct packed {
    logic [7:0] mask2;
    logic [`MASK3_W-1:0] mask3;
    logic [7:0] pend2;
    logic [`MASK3_W-1:0] pend3;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } irq_state_t;

endpackage : line_irq_pkg

// ==== verif/line_interrupt_enable_mask_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "line_irq_defines.svh"

module line_interrupt_enable_mask_test;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [10:0] evt = '0;
  logic irqOut;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int n_compared = 0;
  // Each row holds a mask register index and the one enable bit it tests.
  logic [17:0] rows [0:10] = '{{`IDX_MASK2, 8'h80}, {`IDX_MASK2, 8'h40},
    {`IDX_MASK2, 8'h20}, {`IDX_MASK2, 8'h10}, {`IDX_MASK2, 8'h08},
    {`IDX_MASK2, 8'h04}, {`IDX_MASK2, 8'h02}, {`IDX_MASK2, 8'h01},
    {`IDX_MASK3, 8'h04}, {`IDX_MASK3, 8'h02}, {`IDX_MASK3, 8'h01}};

  always #12.5 core_clk = ~core_clk;

  line_interrupt_enable_mask line_interrupt_enable_mask_i (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alarmEvent(evt[10:5]), .loopClosureEvent(evt[4]),
    .ringTripEvent(evt[3]), .calibErrorEvent(evt[2]),
    .indirectDoneEvent(evt[1]), .toneDetectEvent(evt[0]), .irqOut(irqOut));

  task finish_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [9:0] idx, input logic [7:0] d,
           input logic [3:0] s);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      miscompares++;
      $display("[ERR] %0t no bus answer", $time);
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  // Drives a one-cycle event pulse and lets the interrupt settle.
  task pulse(input logic [10:0] e);
    @(posedge core_clk);
    evt <= e;
    @(posedge core_clk);
    evt <= '0;
    #1;
  endtask : pulse

  initial
  begin
    logic [9:0] mi;
    logic [7:0] b;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    apb(1'b0, `IDX_MASK2, 8'h00, 4'hF);
    chk(rd, 32'h0);
    apb(1'b0, `IDX_MASK3, 8'h00, 4'hF);
    chk(rd, 32'h0);
    for (int i = 0; i < 11; i++)
    begin
      mi = rows[i][17:8];
      b = rows[i][7:0];
      apb(1'b1, mi, b, 4'hF);
      apb(1'b0, mi, 8'h00, 4'hF);
      chk(rd, {24'h0, b});
      pulse(11'h400 >> i);
      chk({31'h0, irqOut}, 32'h1);
      apb(1'b0, mi - 10'h3, 8'h00, 4'hF);
      chk(rd, {24'h0, b});
      apb(1'b1, mi - 10'h3, ~b, 4'hF);
      chk({31'h0, irqOut}, 32'h1);
      apb(1'b1, mi - 10'h3, b, 4'hF);
      chk({31'h0, irqOut}, 32'h0);
      apb(1'b1, mi, 8'h00, 4'hF);
      pulse(11'h400 >> i);
      chk({31'h0, irqOut}, 32'h0);
      apb(1'b1, mi, b, 4'hF);
      chk({31'h0, irqOut}, 32'h1);
      apb(1'b1, mi, 8'h00, 4'hF);
      chk({31'h0, irqOut}, 32'h0);
      apb(1'b1, mi - 10'h3, b, 4'hF);
    end
    apb(1'b1, `IDX_MASK3, 8'hFF, 4'hF);
    apb(1'b0, `IDX_MASK3, 8'h00, 4'hF);
    chk(rd, 32'h7);
    apb(1'b0, 10'h015, 8'h00, 4'hF);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, `IDX_MASK2, 8'hFF, 4'h0);
    apb(1'b0, `IDX_MASK2, 8'h00, 4'hF);
    chk(rd, 32'h0);
    apb(1'b1, `IDX_MASK2, 8'hFF, 4'hF);
    pulse(11'h7F8);
    chk({31'h0, irqOut}, 32'h1);
    // A ring trip in the very cycle of its clear must stay pending.
    fork
      apb(1'b1, `IDX_PEND2, 8'hFF, 4'hF);
      begin
        @(posedge core_clk);
        pulse(11'h008);
      end
    join
    chk({31'h0, irqOut}, 32'h1);
    apb(1'b0, `IDX_PEND2, 8'h00, 4'hF);
    chk(rd, 32'h1);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    chk({31'h0, irqOut}, 32'h0);
    apb(1'b0, `IDX_MASK2, 8'h00, 4'hF);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule : line_interrupt_enable_mask_test
`default_nettype wire
